/* logic/universal_macrocell_logic_array.v */
// sum-of-products array with eight configurable output macrocells
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "macrocell_array_defs.vh"

module universal_macrocell_logic_array #(
    parameter NUM_INPUTS = 8,
    parameter NUM_CELLS  = 8,
    parameter NUM_TERMS  = 8
) (
    input  wire                  clk_sys,
    input  wire                  rst,
    input  wire [NUM_INPUTS-1:0] in_pin,
    input  wire                  clk_pin,
    input  wire                  oe_n_pin,
    input  wire [NUM_CELLS-1:0]  io_in,
    output reg  [NUM_CELLS-1:0]  io_out,
    output reg  [NUM_CELLS-1:0]  io_oe,
    input  wire [7:0]            addr,
    input  wire [31:0]           wr_data,
    input  wire                  wr_en,
    input  wire                  rd_en,
    output reg  [31:0]           rd_data
);

    localparam NUM_SIG   = NUM_INPUTS + NUM_CELLS;
    localparam NUM_COLS  = 2 * NUM_SIG;
    localparam NUM_WORDS = NUM_CELLS * NUM_TERMS;
    localparam SYNC_W    = NUM_INPUTS + NUM_CELLS + 2;

    // -------------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------------
    reg  [SYNC_W-1:0]     sync_a_q;
    reg  [SYNC_W-1:0]     sync_b_q;
    reg                   clk_prev_q;
    wire [NUM_INPUTS-1:0] in_s;
    wire [NUM_CELLS-1:0]  io_s;
    wire                  clk_s;
    wire                  oe_n_s;
    wire                  clk_rise;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync_a_q   <= {SYNC_W{1'b0}};
            sync_b_q   <= {SYNC_W{1'b0}};
            clk_prev_q <= 1'b0;
        end else begin
            sync_a_q   <= {oe_n_pin, clk_pin, io_in, in_pin};
            sync_b_q   <= sync_a_q;
            clk_prev_q <= sync_b_q[SYNC_W-2];
        end
    end

    assign in_s     = sync_b_q[NUM_INPUTS-1:0];
    assign io_s     = sync_b_q[NUM_INPUTS+NUM_CELLS-1:NUM_INPUTS];
    assign clk_s    = sync_b_q[SYNC_W-2];
    assign oe_n_s   = sync_b_q[SYNC_W-1];
    // shared clock pin sampled, so its rate must stay well under clk_sys / 2
    assign clk_rise = clk_s & ~clk_prev_q;

    // -------------------------------------------------------------------------
    // configuration storage
    // -------------------------------------------------------------------------
    reg  [NUM_COLS-1:0]   fuse_q [0:NUM_WORDS-1];
    reg  [`CTRL_WIDTH-1:0] ctrl_q;
    wire                  reg_allow;
    wire                  family_sel;
    wire [NUM_CELLS-1:0]  cfg_sel;
    wire [NUM_CELLS-1:0]  polarity;
    wire                  fuse_wr;
    wire                  ctrl_wr;
    integer               w;

    // status and unmapped addresses take no write
    assign fuse_wr = wr_en & (addr <= `ADDR_FUSE_LAST);
    assign ctrl_wr = wr_en & (addr == `ADDR_CONTROL);

    // fuse words and control word are loaded before use; no shadowing is done
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (w = 0; w < NUM_WORDS; w = w + 1) begin
                fuse_q[w] <= {NUM_COLS{1'b0}};
            end
            ctrl_q <= `RST_CONTROL;
        end else begin
            if (fuse_wr) begin
                fuse_q[addr[5:0]] <= wr_data[NUM_COLS-1:0];
            end
            if (ctrl_wr) begin
                ctrl_q <= wr_data[`CTRL_WIDTH-1:0];
            end
        end
    end

    assign reg_allow  = ctrl_q[`CTRL_REG_ALLOW_POS];
    assign family_sel = ctrl_q[`CTRL_FAMILY_POS];
    assign cfg_sel    = ctrl_q[`CTRL_SELECT_LSB +: NUM_CELLS];
    assign polarity   = ctrl_q[`CTRL_POLARITY_LSB +: NUM_CELLS];

    // -------------------------------------------------------------------------
    // AND array columns
    // -------------------------------------------------------------------------
    wire [NUM_SIG-1:0]    sig;
    wire [NUM_COLS-1:0]   col;
    wire [NUM_CELLS-1:0]  feedback;
    reg  [NUM_CELLS-1:0]  flop_q;
    wire [NUM_CELLS-1:0]  flop_d;
    wire [NUM_CELLS-1:0]  flop_en;
    wire [NUM_CELLS-1:0]  pin_d;
    wire [NUM_CELLS-1:0]  oe_d;

    assign sig = {feedback, in_s};

    genvar k;
    generate
        for (k = 0; k < NUM_SIG; k = k + 1) begin : g_col
            assign col[2*k]   = sig[k];
            assign col[2*k+1] = ~sig[k];
        end
    endgenerate

    // -------------------------------------------------------------------------
    // macrocells
    // -------------------------------------------------------------------------
    genvar i;
    genvar t;
    generate
        for (i = 0; i < NUM_CELLS; i = i + 1) begin : g_cell
            wire [NUM_TERMS-1:0] pt;
            wire                 io_mode;
            wire                 reg_mode;
            wire                 sum;
            wire                 fb_sel;
            wire                 adjacent;
            wire [NUM_TERMS-1:0] pt_mask;
            reg                  oe_c;
            reg                  out_c;
            reg                  fb_c;

            for (t = 0; t < NUM_TERMS; t = t + 1) begin : g_term
                // open fuse passes 1, so an empty term is high and a
                // true/inverted pair forces low
                assign pt[t] = &(~fuse_q[i*NUM_TERMS+t] | col);
            end

            assign io_mode  = family_sel & cfg_sel[i];
            assign reg_mode = ~reg_allow & family_sel & ~cfg_sel[i];
            // product-term input mux: first term goes to the enable in I/O modes
            assign pt_mask = {{(NUM_TERMS-1){1'b1}}, ~io_mode};
            assign sum     = |(pt & pt_mask);

            // registered pin shows inverted flop, so d carries the xor
            assign flop_d[i]  = sum ^ polarity[i];
            assign flop_en[i] = reg_mode & clk_rise;
            // output select mux
            always @* begin
                case (reg_mode)
                    1'b1:    out_c = ~flop_q[i];
                    default: out_c = ~(sum ^ polarity[i]);
                endcase
            end
            assign pin_d[i] = out_c;

            // enable select mux
            always @* begin
                case ({family_sel, cfg_sel[i]})
                    2'b10:   oe_c = ~oe_n_s;
                    2'b11:   oe_c = pt[0];
                    2'b00:   oe_c = 1'b1;
                    default: oe_c = 1'b0;
                endcase
            end
            assign oe_d[i] = oe_c;

            // feedback select mux; end cells see the clock and enable pins
            if (i == 0) begin : g_fb_low
                assign fb_sel   = ~reg_allow;
                assign adjacent = oe_n_s;
            end else if (i == NUM_CELLS-1) begin : g_fb_high
                assign fb_sel   = ~reg_allow;
                assign adjacent = clk_s;
            end else if (i == NUM_CELLS/2-1 || i == NUM_CELLS/2) begin : g_fb_mid
                // the two centre cells have no neighbour path
                assign fb_sel   = family_sel;
                assign adjacent = 1'b0;
            end else if (i < NUM_CELLS/2) begin : g_fb_lo_half
                assign fb_sel   = family_sel;
                assign adjacent = io_s[i-1];
            end else begin : g_fb_hi_half
                assign fb_sel   = family_sel;
                assign adjacent = io_s[i+1];
            end

            // feedback mux: flop, own pin, or neighbour path
            always @* begin
                case ({fb_sel, cfg_sel[i]})
                    2'b10:   fb_c = ~flop_q[i];
                    2'b11:   fb_c = io_s[i];
                    default: fb_c = adjacent;
                endcase
            end
            assign feedback[i] = fb_c;
        end
    endgenerate

    // -------------------------------------------------------------------------
    // macrocell flops and pin registers
    // -------------------------------------------------------------------------
    integer c;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flop_q <= {NUM_CELLS{1'b0}};
            io_out <= {NUM_CELLS{1'b0}};
            io_oe  <= {NUM_CELLS{1'b0}};
        end else begin
            for (c = 0; c < NUM_CELLS; c = c + 1) begin
                if (flop_en[c]) begin
                    flop_q[c] <= flop_d[c];
                end
            end
            io_out <= pin_d;
            io_oe  <= oe_d;
        end
    end

    // -------------------------------------------------------------------------
    // register read port
    // -------------------------------------------------------------------------
    reg  [31:0]           fuse_rd;
    reg  [31:0]           rd_mux;
    wire [31:0]           ctrl_rd;
    wire [31:0]           status_rd;
    integer               b;

    // fuse word copied bit by bit, so column counts up to 32 read back zero padded, wider ones cut to 32
    always @* begin
        fuse_rd = `RST_DATA;
        for (b = 0; b < NUM_COLS && b < 32; b = b + 1) begin
            fuse_rd[b] = fuse_q[addr[5:0]][b];
        end
    end

    assign ctrl_rd   = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_q};
    assign status_rd = {8'h00, flop_q, io_oe, io_out};

    // unmapped addresses read as zero
    always @* begin
        rd_mux = `RST_DATA;
        if (addr <= `ADDR_FUSE_LAST) begin
            rd_mux = fuse_rd;
        end else if (addr == `ADDR_CONTROL) begin
            rd_mux = ctrl_rd;
        end else if (addr == `ADDR_STATUS) begin
            rd_mux = status_rd;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_data <= `RST_DATA;
        end else if (rd_en) begin
            rd_data <= rd_mux;
        end else begin
            // data stands only in the cycle after the strobe
            rd_data <= `RST_DATA;
        end
    end

endmodule

/* shared/macrocell_array_defs.vh */
// constants for the universal macrocell logic array
`ifndef MACROCELL_ARRAY_DEFS_VH
`define MACROCELL_ARRAY_DEFS_VH

// -----------------------------------------------------------------------------
// register word addresses
// -----------------------------------------------------------------------------
`define ADDR_FUSE_BASE      8'h00
`define ADDR_FUSE_LAST      8'h3F
`define ADDR_CONTROL        8'h40
`define ADDR_STATUS         8'h41

// -----------------------------------------------------------------------------
// control word fields
// -----------------------------------------------------------------------------
`define CTRL_REG_ALLOW_POS  0
`define CTRL_FAMILY_POS     1
`define CTRL_SELECT_LSB     2
`define CTRL_POLARITY_LSB   10
`define CTRL_WIDTH          18

// -----------------------------------------------------------------------------
// status word fields
// -----------------------------------------------------------------------------
`define STAT_OUT_LSB        0
`define STAT_OE_LSB         8
`define STAT_FLOP_LSB       16

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define RST_CONTROL         18'h00000
`define RST_FUSE            32'h00000000
`define RST_DATA            32'h00000000

`endif

/* verification/macrocell_monitor.sv */
// port checker for the macrocell array
`timescale 1ns/1ps
module macrocell_monitor (
    input wire        clk_sys,
    input wire        rst,
    input wire        clk_pin,
    input wire        oe_n_pin,
    input wire [7:0]  io_out,
    input wire [7:0]  io_oe,
    input wire [7:0]  addr,
    input wire [31:0] wr_data,
    input wire        wr_en,
    input wire        rd_en,
    input wire [31:0] rd_data
);
    // ----------------------------------------
    // shadow of the control word and pin history
    // ----------------------------------------
    logic [17:0] ctl_q;
    logic [3:0]  age_q;
    logic [7:0]  ck_q;
    logic [4:0]  oe_q;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_q <= 18'h00000;
            age_q <= 4'h0;
            ck_q  <= 8'h00;
            oe_q  <= 5'h00;
        end else begin
            ck_q <= {ck_q[6:0], clk_pin};
            oe_q <= {oe_q[3:0], oe_n_pin};
            if (wr_en && addr == 8'h40) begin
                ctl_q <= wr_data[17:0];
                age_q <= 4'h0;
            end else if (age_q != 4'hF) begin
                age_q <= age_q + 4'h1;
            end
        end
    end
    // pin checks wait for the pin synchronisers and the mode change to settle
    wire       ok    = age_q == 4'hF;
    wire [7:0] reg_m = (!ctl_q[0] && ctl_q[1]) ? ~ctl_q[9:2] : 8'h00;
    wire [7:0] out_m = (ctl_q[0] && !ctl_q[1]) ? ~ctl_q[9:2] : 8'h00;
    wire [7:0] in_m  = (ctl_q[0] && !ctl_q[1]) ? ctl_q[9:2] : 8'h00;
    wire       rise  = |(ck_q[6:0] & ~ck_q[7:1]);
    wire       oe_st = oe_q == 5'h00 || oe_q == 5'h1F;
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_ctl_read;
        rd_en && addr == 8'h40;
    endsequence
    sequence s_stat_read;
        rd_en && addr == 8'h41;
    endsequence
    a_input_drv_off: assert property (ok |-> (io_oe & in_m) == 8'h00)
        else $error("input cell drives its pin");
    a_comb_out_on: assert property (ok |-> (io_oe & out_m) == out_m)
        else $error("combinatorial output not driven");
    a_reg_oe_pin: assert property (ok && oe_st |->
        (io_oe & reg_m) == (oe_q[0] ? 8'h00 : reg_m)) else $error("registered enable wrong");
    a_reg_out_clk: assert property (ok && ((io_out ^ $past(io_out)) & reg_m) != 8'h00
        |-> rise) else $error("registered output moved without clock");
    a_rd_idle_zero: assert property (!rd_en |=> rd_data == 32'h00000000)
        else $error("read data outside read slot");
    a_ctl_read_back: assert property (s_ctl_read |=> rd_data[17:0] == ctl_q)
        else $error("control word read back wrong");
    a_stat_mirror: assert property (s_stat_read |=>
        rd_data[15:0] == $past({io_oe, io_out})) else $error("status does not mirror pins");
    a_reset_clear: assert property ($fell(rst) |-> io_oe == 8'h00 && io_out == 8'h00)
        else $error("pins not clear after reset");
endmodule

/* verification/board_model.sv */
// board logic driving inputs, clock pin and enable pin
`timescale 1ns/1ps
module board_model (
    input  wire        clk_sys,
    input  wire  [7:0] io_out,
    input  wire  [7:0] io_oe,
    output logic [7:0] in_pin,
    output logic       clk_pin,
    output logic       oe_n_pin,
    output wire  [7:0] io_in
);
    // ----------------------------------------
    // pin levels
    // ----------------------------------------
    logic [7:0] ext_q = 8'h00;
    initial begin
        in_pin = 8'h00;
        clk_pin = 1'b0;
        oe_n_pin = 1'b1;
    end
    // a driving cell wins the wire, otherwise the board level shows
    assign io_in = (io_oe & io_out) | (~io_oe & ext_q);
    task automatic set(input [7:0] i, input oe_n, input [7:0] e);
        @(posedge clk_sys);
        in_pin <= i;
        oe_n_pin <= oe_n;
        ext_q <= e;
    endtask
    // hold sets the clock pin phase length, short or slow
    task automatic tick(input int hold);
        @(posedge clk_sys);
        clk_pin <= 1'b1;
        repeat (hold) @(posedge clk_sys);
        clk_pin <= 1'b0;
        repeat (hold) @(posedge clk_sys);
    endtask
endmodule

/* verification/testbench.sv */
// self-checking bench for the macrocell array
`timescale 1ns/1ps
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    wire  [7:0]  in_pin, io_in, io_out, io_oe;
    wire         clk_pin, oe_n_pin;
    wire  [31:0] rd_data;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    always #2 clk_sys = ~clk_sys;
    universal_macrocell_logic_array u_universal_macrocell_logic_array (
        .clk_sys(clk_sys), .rst(rst), .in_pin(in_pin), .clk_pin(clk_pin),
        .oe_n_pin(oe_n_pin), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
    board_model u_board (.clk_sys(clk_sys), .io_out(io_out), .io_oe(io_oe), .in_pin(in_pin),
        .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_in(io_in));
    // ----------------------------------------
    // register port tasks
    // ----------------------------------------
    task automatic give_verdict;
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [31:0] m, input [31:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        total_checks++;
        if ((rd_data & m) !== e) begin
            $display("ERROR t=%0t got %h exp %h", $time, rd_data & m, e);
            bad_count++;
        end
    endtask
    // pins need three edges to reach the outputs, six leaves margin
    task automatic st(input [31:0] m, input [31:0] e);
        repeat (6) @(posedge clk_sys);
        rd(8'h41, m, e);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h40, 32'h3FFFF, 32'h0);
        rd(8'h41, 32'hFF0000, 32'h0);
        rd(8'h80, 32'hFFFFFFFF, 32'h0);
        wr(8'h40, 32'h3FC01);
        rd(8'h40, 32'h3FFFF, 32'h3FC01);
        st(32'hFFFFFF, 32'h00FFFF);
        wr(8'h40, 32'h00001);
        st(32'hFFFFFF, 32'h00FF00);
        wr(8'h40, 32'h3FC01);
        for (int t = 0; t < 7; t++) wr(8'h08 + t[7:0], 32'h3);
        st(32'hFFFFFF, 32'h00FFFF);
        wr(8'h0F, 32'h3);
        st(32'hFFFFFF, 32'h00FFFD);
        for (int t = 1; t < 8; t++) wr(8'h10 + t[7:0], 32'h3);
        wr(8'h10, 32'h1);
        st(32'hFFFFFF, 32'h00FFF9);
        u_board.set(8'h01, 1'b1, 8'h00);
        st(32'hFFFFFF, 32'h00FFFD);
        wr(8'h10, 32'h2);
        st(32'hFFFFFF, 32'h00FFF9);
        wr(8'h40, 32'h3FC81);
        st(32'h00FF00, 32'h00DF00);
        wr(8'h40, 32'h3FC22);
        st(32'hFFFFFF, 32'h0008FF);
        u_board.tick(4);
        st(32'hF7FFFF, 32'h0608F9);
        u_board.set(8'h01, 1'b0, 8'h00);
        st(32'hF7FFFF, 32'h06FFF9);
        u_board.tick(8);
        st(32'hF7FFFF, 32'h06FFF9);
        wr(8'h40, 32'h3FFFF);
        wr(8'h09, 32'h10000);
        wr(8'h11, 32'h40000);
        st(32'hFFFFFF, 32'h06F9F9);
        u_board.set(8'h01, 1'b1, 8'h02);
        st(32'hFFFFFF, 32'h06F9FF);
        give_verdict();
    end
endmodule
bind universal_macrocell_logic_array macrocell_monitor u_mon (
    .clk_sys(clk_sys), .rst(rst), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_out(io_out),
    .io_oe(io_oe), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data));
